// [logic/ptls_pkg.sv]
`default_nettype none
package ptls_pkg;
  // Register byte offsets
  localparam logic [7:0] PTLS_CTRL_OFS = 8'h00;
  localparam logic [7:0] PTLS_STAT_OFS = 8'h04;
  localparam logic [7:0] PTLS_TXCODE_OFS = 8'h08;
  localparam logic [7:0] PTLS_DEVAB_OFS = 8'h0C;
  localparam logic [7:0] PTLS_PARTAB_OFS = 8'h10;
  localparam logic [7:0] PTLS_RXCODE_OFS = 8'h14;
  localparam logic [7:0] PTLS_ERRCNT_OFS = 8'h18;
  // Control bit positions
  localparam int PTLS_CTRL_AN_EN = 0;
  localparam int PTLS_CTRL_AN_RESTART = 1;
  localparam int PTLS_CTRL_SGMII = 2;
  localparam int PTLS_CTRL_PHY_SIDE = 3;
  localparam int PTLS_CTRL_HALF_DUP = 4;
  localparam int PTLS_CTRL_PWRDN = 5;
  localparam int PTLS_CTRL_LOOPBACK = 6;
  localparam int PTLS_CTRL_W = 7;
  // Ability bit that marks link up
  localparam int PTLS_ABIL_LINK = 15;
  // Reset values
  localparam logic [PTLS_CTRL_W-1:0] PTLS_CTRL_RST = 7'h00;
  localparam logic [15:0] PTLS_ABIL_RST = 16'h0000;
  // Code groups
  localparam logic [9:0] PTLS_K285_NEG = 10'h0FA;
  localparam logic [9:0] PTLS_D162_NEG = 10'h245;
  localparam logic [9:0] PTLS_D162_POS = 10'h1B5;
  localparam logic [9:0] PTLS_D56 = 10'h296;
  localparam logic [6:0] PTLS_COMMA_NEG = 7'h1F;
  localparam logic [6:0] PTLS_COMMA_POS = 7'h60;
  // Sync acquisition
  localparam logic [1:0] PTLS_SYNC_BAD_MAX = 2'h3;
  // ECC status codes
  localparam logic [1:0] PTLS_ECC_NONE = 2'h0;
  localparam logic [1:0] PTLS_ECC_CORR = 2'h2;
  localparam logic [1:0] PTLS_ECC_UNCORR = 2'h3;
  // Timing
  localparam int PTLS_CLK_MHZ = 100;
  localparam int PTLS_AN_LINK_TIME_US = 10;
  localparam int PTLS_AN_LINK_CYCLES = PTLS_AN_LINK_TIME_US * PTLS_CLK_MHZ;
  localparam logic [15:0] PTLS_CNT_MAX = 16'hFFFF;

  function automatic logic [3:0] ptls_ones(input logic [9:0] g);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++)
    begin
      n = n + {3'b000, g[i]};
    end
    return n;
  endfunction

  function automatic logic ptls_is_comma(input logic [9:0] g);
    return (g[9:3] == PTLS_COMMA_NEG) || (g[9:3] == PTLS_COMMA_POS);
  endfunction

  function automatic logic ptls_is_idle(input logic [9:0] g);
    return ptls_is_comma(g) || (g == PTLS_D162_NEG) || (g == PTLS_D162_POS) ||
      (g == PTLS_D56);
  endfunction
endpackage
`default_nettype wire

// [logic/ptls_align_if.sv]
`default_nettype none
interface ptls_align_if;
  logic [9:0] word;
  logic word_stb;
  logic [9:0] grp;
  logic grp_stb;
  logic char_err;
  logic disp_err;
  logic sync_ok;
  modport aligner (input word, word_stb, output grp, grp_stb, char_err, disp_err, sync_ok);
  modport core (output word, word_stb, input grp, grp_stb, char_err, disp_err, sync_ok);
endinterface
`default_nettype wire

// [logic/ptls_align.sv]
`default_nettype none
module ptls_align
  import ptls_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Word stream
  ptls_align_if.aligner al
);
  typedef enum logic [1:0] {PTLS_LOSS, PTLS_ACQ1, PTLS_ACQ2, PTLS_SYNC} ptls_sync_t;

  logic [9:0] prev_reg;
  logic [3:0] ofs_reg;
  logic [3:0] ofs_next;
  logic [9:0] grp_reg;
  logic grp_stb_reg;
  logic char_reg;
  logic disp_reg;
  logic rd_reg;
  logic rd_next;
  logic [1:0] bad_reg;
  ptls_sync_t st_reg;
  ptls_sync_t st_next;
  logic [19:0] combo;
  logic comma_hit;
  logic [3:0] comma_ofs;
  logic [9:0] win;
  logic [3:0] ones;
  logic bad_char;
  logic bad_disp;
  logic win_comma;

  assign combo = {prev_reg, al.word};
  assign ofs_next = comma_hit ? comma_ofs : ofs_reg;
  assign win = combo[19 - 32'(ofs_next) -: 10];
  assign ones = ptls_ones(win);
  assign win_comma = ptls_is_comma(win);
  assign bad_char = (ones < 4'd4) || (ones > 4'd6);
  assign bad_disp = ((ones == 4'd6) && rd_reg) || ((ones == 4'd4) && !rd_reg);
  assign rd_next = (ones == 4'd6) ? 1'b1 : (ones == 4'd4) ? 1'b0 : rd_reg;

  // Search every bit offset for a comma
  always_comb
  begin
    comma_hit = 1'b0;
    comma_ofs = 4'h0;
    for (int k = 9; k >= 0; k--)
    begin
      if (ptls_is_comma(combo[19 - k -: 10]))
      begin
        comma_hit = 1'b1;
        comma_ofs = 4'(k);
      end
    end
  end

  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      PTLS_LOSS: if (win_comma && !bad_char) st_next = PTLS_ACQ1;
      PTLS_ACQ1: if (bad_char) st_next = PTLS_LOSS; else if (win_comma) st_next = PTLS_ACQ2;
      PTLS_ACQ2: if (bad_char) st_next = PTLS_LOSS; else if (win_comma) st_next = PTLS_SYNC;
      PTLS_SYNC: if (bad_char && bad_reg == PTLS_SYNC_BAD_MAX) st_next = PTLS_LOSS;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prev_reg <= 10'h000;
      ofs_reg <= 4'h0;
      grp_reg <= 10'h000;
      grp_stb_reg <= 1'b0;
      char_reg <= 1'b0;
      disp_reg <= 1'b0;
      rd_reg <= 1'b0;
      bad_reg <= 2'h0;
      st_reg <= PTLS_LOSS;
    end
    else
    begin
      grp_stb_reg <= al.word_stb;
      if (al.word_stb)
      begin
        prev_reg <= al.word;
        ofs_reg <= ofs_next;
        grp_reg <= win;
        char_reg <= bad_char;
        disp_reg <= bad_disp && !bad_char;
        rd_reg <= rd_next;
        st_reg <= st_next;
        bad_reg <= (st_next != PTLS_SYNC) ? 2'h0 : bad_char ? bad_reg + 2'h1 : bad_reg;
      end
    end
  end

  assign al.grp = grp_reg;
  assign al.grp_stb = grp_stb_reg;
  assign al.char_err = char_reg;
  assign al.disp_err = disp_reg;
  assign al.sync_ok = (st_reg == PTLS_SYNC);
endmodule
`default_nettype wire

// [logic/ptls_top.sv]
// Local design decisions: the APB interface to the registers and the register offsets.
`default_nettype none
module ptls_top
  import ptls_pkg::*;
#(
  parameter int AN_LINK_CYCLES = PTLS_AN_LINK_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Ten-bit interface
  input wire logic tbi_tx_clk,
  output logic [9:0] tbi_tx_d,
  input wire logic tbi_rx_clk,
  input wire logic [9:0] tbi_rx_d,
  // Status indicators
  output logic led_link,
  output logic led_panel_link,
  output logic led_crs,
  output logic led_col,
  output logic autoneg_done_indicator,
  output logic led_char_err,
  output logic led_disp_err,
  // Serializer control
  output logic powerdown,
  output logic serializer_loopback_out,
  // Memory ECC
  input wire logic ecc_corrected,
  input wire logic ecc_uncorrectable,
  output logic [1:0] ecc_status
);
  import ptls_pkg::*;

  ptls_align_if al ();

  // Clock and data synchronisers
  logic [2:0] txc_reg;
  logic [2:0] rxc_reg;
  logic [9:0] rxd1_reg;
  logic [9:0] rxd2_reg;
  logic tx_rise;
  logic rx_rise;
  logic rx_fall;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txc_reg <= 3'h0;
      rxc_reg <= 3'h0;
      rxd1_reg <= 10'h000;
      rxd2_reg <= 10'h000;
    end
    else
    begin
      txc_reg <= {txc_reg[1:0], tbi_tx_clk};
      rxc_reg <= {rxc_reg[1:0], tbi_rx_clk};
      rxd1_reg <= tbi_rx_d;
      rxd2_reg <= rxd1_reg;
    end
  end

  assign tx_rise = txc_reg[1] && !txc_reg[2];
  assign rx_rise = rxc_reg[1] && !rxc_reg[2];
  assign rx_fall = !rxc_reg[1] && rxc_reg[2];

  // Receive words taken mid-cycle of the receive clock
  assign al.word = rxd2_reg;
  assign al.word_stb = rx_fall;

  ptls_align u_align (
    .ref_clk(ref_clk),
    .rst(rst),
    .al(al)
  );

  // Register file
  logic [PTLS_CTRL_W-1:0] ctrl_reg;
  logic [9:0] txcode_reg;
  logic [15:0] devab_reg;
  logic [15:0] partab_reg;
  logic [9:0] rxcode_reg;
  logic [15:0] char_cnt_reg;
  logic [15:0] disp_cnt_reg;
  logic wr_en;
  logic rd_acc;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_tx;
  logic hit_dev;
  logic hit_part;
  logic hit_rx;
  logic hit_err;
  logic mapped;
  logic an_restart;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  assign hit_ctrl = (paddr == PTLS_CTRL_OFS);
  assign hit_stat = (paddr == PTLS_STAT_OFS);
  assign hit_tx = (paddr == PTLS_TXCODE_OFS);
  assign hit_dev = (paddr == PTLS_DEVAB_OFS);
  assign hit_part = (paddr == PTLS_PARTAB_OFS);
  assign hit_rx = (paddr == PTLS_RXCODE_OFS);
  assign hit_err = (paddr == PTLS_ERRCNT_OFS);
  assign mapped = hit_ctrl | hit_stat | hit_tx | hit_dev | hit_part | hit_rx | hit_err;
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_acc = psel && penable && !pwrite;
  assign an_restart = wr_en && hit_ctrl && pwdata[PTLS_CTRL_AN_RESTART];
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_reg <= PTLS_CTRL_RST;
      txcode_reg <= PTLS_K285_NEG;
      devab_reg <= PTLS_ABIL_RST;
      partab_reg <= PTLS_ABIL_RST;
    end
    else if (wr_en)
    begin
      if (hit_ctrl)
      begin
        ctrl_reg <= pwdata[PTLS_CTRL_W-1:0] & ~(7'h01 << PTLS_CTRL_AN_RESTART);
      end
      if (hit_tx)
      begin
        txcode_reg <= pwdata[9:0];
      end
      if (hit_dev)
      begin
        devab_reg <= pwdata[15:0];
      end
      if (hit_part)
      begin
        partab_reg <= pwdata[15:0];
      end
    end
  end

  // Error counters: a clear in the same cycle as an increment leaves the count at one
  logic err_clr;
  assign err_clr = wr_en && hit_err;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      char_cnt_reg <= 16'h0000;
      disp_cnt_reg <= 16'h0000;
      rxcode_reg <= 10'h000;
    end
    else
    begin
      if (al.grp_stb)
      begin
        rxcode_reg <= al.grp;
      end
      if (al.grp_stb && al.char_err)
      begin
        char_cnt_reg <= err_clr ? 16'h0001 :
          (char_cnt_reg == PTLS_CNT_MAX) ? char_cnt_reg : char_cnt_reg + 16'h0001;
      end
      else if (err_clr)
      begin
        char_cnt_reg <= 16'h0000;
      end
      if (al.grp_stb && al.disp_err)
      begin
        disp_cnt_reg <= err_clr ? 16'h0001 :
          (disp_cnt_reg == PTLS_CNT_MAX) ? disp_cnt_reg : disp_cnt_reg + 16'h0001;
      end
      else if (err_clr)
      begin
        disp_cnt_reg <= 16'h0000;
      end
    end
  end

  // Transmit path
  logic [9:0] txd_reg;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txd_reg <= PTLS_K285_NEG;
    end
    else if (tx_rise)
    begin
      txd_reg <= txcode_reg;
    end
  end

  assign tbi_tx_d = txd_reg;

  // Auto-negotiation completion timer
  logic [31:0] an_cnt_reg;
  logic an_done_reg;
  logic an_en;
  logic sgmii;
  logic phy_side;
  logic half_dup;

  assign an_en = ctrl_reg[PTLS_CTRL_AN_EN];
  assign sgmii = ctrl_reg[PTLS_CTRL_SGMII];
  assign phy_side = ctrl_reg[PTLS_CTRL_PHY_SIDE];
  assign half_dup = ctrl_reg[PTLS_CTRL_HALF_DUP];

  always_ff @(posedge ref_clk)
  begin
    if (rst || !an_en || an_restart || !al.sync_ok)
    begin
      an_cnt_reg <= 32'h0000_0000;
      an_done_reg <= 1'b0;
    end
    else if (an_cnt_reg >= 32'(AN_LINK_CYCLES - 1))
    begin
      an_done_reg <= 1'b1;
    end
    else
    begin
      an_cnt_reg <= an_cnt_reg + 32'h0000_0001;
    end
  end

  // Activity tracking
  logic rx_act_reg;
  logic tx_act;

  always_ff @(posedge ref_clk)
  begin
    if (rst || !al.sync_ok)
    begin
      rx_act_reg <= 1'b0;
    end
    else if (al.grp_stb)
    begin
      rx_act_reg <= !ptls_is_idle(al.grp);
    end
  end

  assign tx_act = !ptls_is_idle(txd_reg);

  // Indicator decode
  logic panel_next;
  logic col_next;
  logic crs_next;

  assign panel_next = !an_en ? al.sync_ok :
    !sgmii ? an_done_reg :
    phy_side ? (an_done_reg && devab_reg[PTLS_ABIL_LINK]) :
    (an_done_reg && partab_reg[PTLS_ABIL_LINK]);
  assign crs_next = rx_act_reg || tx_act;
  assign col_next = sgmii && half_dup && tx_act && rx_act_reg;

  // Receive error pulses held for one receive clock period
  logic char_led_reg;
  logic disp_led_reg;
  logic char_pend_reg;
  logic disp_pend_reg;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      char_pend_reg <= 1'b0;
      disp_pend_reg <= 1'b0;
      char_led_reg <= 1'b0;
      disp_led_reg <= 1'b0;
    end
    else
    begin
      if (al.grp_stb)
      begin
        char_pend_reg <= al.char_err;
        disp_pend_reg <= al.disp_err;
      end
      if (rx_rise)
      begin
        char_led_reg <= char_pend_reg;
        disp_led_reg <= disp_pend_reg;
        char_pend_reg <= al.grp_stb && al.char_err;
        disp_pend_reg <= al.grp_stb && al.disp_err;
      end
    end
  end

  // Registered indicators and controls
  logic link_reg;
  logic panel_reg;
  logic crs_reg;
  logic col_reg;
  logic [1:0] ecc_reg;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      link_reg <= 1'b0;
      panel_reg <= 1'b0;
      crs_reg <= 1'b0;
      col_reg <= 1'b0;
      ecc_reg <= PTLS_ECC_NONE;
    end
    else
    begin
      link_reg <= al.sync_ok;
      panel_reg <= panel_next;
      crs_reg <= crs_next;
      col_reg <= col_next;
      ecc_reg <= ecc_uncorrectable ? PTLS_ECC_UNCORR :
        ecc_corrected ? PTLS_ECC_CORR : PTLS_ECC_NONE;
    end
  end

  assign led_link = link_reg;
  assign led_panel_link = panel_reg;
  assign led_crs = crs_reg;
  assign led_col = col_reg;
  assign autoneg_done_indicator = an_done_reg;
  assign led_char_err = char_led_reg;
  assign led_disp_err = disp_led_reg;
  assign powerdown = ctrl_reg[PTLS_CTRL_PWRDN];
  assign serializer_loopback_out = ctrl_reg[PTLS_CTRL_LOOPBACK];
  assign ecc_status = ecc_reg;

  // Read data
  assign stat_word = {25'h000_0000, col_reg, crs_reg, panel_reg, an_done_reg,
    tx_act, rx_act_reg, al.sync_ok};

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl)
    begin
      rd_word = {25'h000_0000, ctrl_reg};
    end
    else if (hit_stat)
    begin
      rd_word = stat_word;
    end
    else if (hit_tx)
    begin
      rd_word = {22'h00_0000, txcode_reg};
    end
    else if (hit_dev)
    begin
      rd_word = {16'h0000, devab_reg};
    end
    else if (hit_part)
    begin
      rd_word = {16'h0000, partab_reg};
    end
    else if (hit_rx)
    begin
      rd_word = {22'h00_0000, rxcode_reg};
    end
    else if (hit_err)
    begin
      rd_word = {disp_cnt_reg, char_cnt_reg};
    end
  end

  assign prdata = rd_acc ? rd_word : 32'h0000_0000;
endmodule
`default_nettype wire

// [tb/ptls_serdes_model.sv]
`default_nettype none
module ptls_serdes_model
  import ptls_pkg::*;
#(
  parameter int SHIFT = 3
)
(
  // Bench control
  input wire logic ovr_valid,
  input wire logic [9:0] ovr_a,
  input wire logic [9:0] ovr_b,
  output logic took,
  // Ten-bit link
  output logic tbi_tx_clk,
  output logic tbi_rx_clk,
  output logic [9:0] tbi_rx_d
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [19:0] sr;
  logic k_slot;
  logic use_b;
  logic [9:0] nxt;
  initial
  begin
    sr = 20'h0_0000;
    k_slot = 1'b1;
    use_b = 1'b0;
    took = 1'b0;
    tbi_rx_clk = 1'b0;
    tbi_tx_clk = 1'b0;
    #37;
    forever #80 tbi_tx_clk = ~tbi_tx_clk;
  end
  always #80 tbi_rx_clk = ~tbi_rx_clk;
  // Idle pairs unless the bench asks for a pair of its own
  assign nxt = k_slot ? (ovr_valid ? ovr_a : PTLS_K285_NEG) : (use_b ? ovr_b : PTLS_D162_NEG);
  always @(posedge tbi_rx_clk)
  begin
    sr <= {sr[9:0], nxt};
    use_b <= k_slot && ovr_valid;
    took <= !k_slot && use_b;
    k_slot <= !k_slot;
  end
  // Words straddle group boundaries
  assign tbi_rx_d = sr[9+SHIFT:SHIFT];
endmodule
`default_nettype wire

// [tb/ptls_top_chk.sv]
`default_nettype none
module ptls_top_chk
  import ptls_pkg::*;
#(
  parameter int AN_LINK_CYCLES = PTLS_AN_LINK_CYCLES,
  parameter int RX_CYC = 16
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Link and status
  input wire logic tbi_tx_clk,
  input wire logic [9:0] tbi_tx_d,
  input wire logic led_link,
  input wire logic led_crs,
  input wire logic led_col,
  input wire logic autoneg_done_indicator,
  input wire logic led_char_err,
  input wire logic led_disp_err,
  input wire logic powerdown,
  input wire logic serializer_loopback_out,
  input wire logic ecc_corrected,
  input wire logic ecc_uncorrectable,
  input wire logic [1:0] ecc_status
);
  logic [7:0] char_len;
  logic [7:0] disp_len;
  int link_run;
  wire ctrl_wr = psel && penable && pwrite && (paddr == PTLS_CTRL_OFS);
  always_ff @(posedge ref_clk)
  begin
    char_len <= (rst || !led_char_err) ? 8'h00 : char_len + 8'h01;
    disp_len <= (rst || !led_disp_err) ? 8'h00 : disp_len + 8'h01;
    link_run <= (rst || !led_link) ? 0 : link_run + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  reset_quiet_a: assert property ($fell(rst) |-> !led_link && !led_crs && !led_col
    && !autoneg_done_indicator && !powerdown && !serializer_loopback_out
    && tbi_tx_d == PTLS_K285_NEG) else $error("outputs not quiet after reset");
  tx_sync_a: assert property ($changed(tbi_tx_d) |-> $past(tbi_tx_clk, 2)
    && !$past(tbi_tx_clk, 7)) else $error("transmit group off its clock");
  char_pulse_a: assert property ($fell(led_char_err) |-> char_len != 8'h00
    && char_len % RX_CYC == 0) else $error("char error pulse length wrong");
  disp_pulse_a: assert property ($fell(led_disp_err) |-> disp_len != 8'h00
    && disp_len % RX_CYC == 0) else $error("disparity pulse length wrong");
  ecc_map_a: assert property (!$past(rst) |-> ecc_status == ($past(ecc_uncorrectable)
    ? PTLS_ECC_UNCORR : ($past(ecc_corrected) ? PTLS_ECC_CORR : PTLS_ECC_NONE)))
    else $error("ecc status wrong");
  ecc_code_a: assert property (ecc_status != 2'b01) else $error("ecc code 01 seen");
  ctrl_write_a: assert property (ctrl_wr |=> powerdown == $past(pwdata[PTLS_CTRL_PWRDN])
    && serializer_loopback_out == $past(pwdata[PTLS_CTRL_LOOPBACK]))
    else $error("control outputs not written");
  ctrl_hold_a: assert property (!ctrl_wr |=> $stable(powerdown)
    && $stable(serializer_loopback_out)) else $error("control outputs moved");
  col_crs_a: assert property (led_col |-> led_crs) else $error("collision without activity");
  an_loss_a: assert property (autoneg_done_indicator && !led_link |-> ##[1:2]
    !autoneg_done_indicator) else $error("negotiation kept without sync");
  an_time_a: assert property ($rose(autoneg_done_indicator) |->
    link_run >= AN_LINK_CYCLES - 2) else $error("negotiation done too early");
  cover property ($rose(led_link));
  cover property ($rose(autoneg_done_indicator));
  cover property ($rose(led_col));
  cover property ($rose(led_char_err));
endmodule
bind ptls_top ptls_top_chk #(.AN_LINK_CYCLES(AN_LINK_CYCLES)) chk_u (.ref_clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .tbi_tx_clk, .tbi_tx_d, .led_link, .led_crs, .led_col,
  .autoneg_done_indicator, .led_char_err, .led_disp_err, .powerdown, .serializer_loopback_out,
  .ecc_corrected, .ecc_uncorrectable, .ecc_status);
`default_nettype wire

// [tb/ptls_top_bench.sv]
`default_nettype none
module ptls_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import ptls_pkg::*;
  localparam int AN_CYC = 20;
  localparam logic [9:0] DATA_GRP = 10'h2A5;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, e, tbi_tx_clk, tbi_rx_clk, took;
  logic [9:0] tbi_tx_d, tbi_rx_d;
  logic [9:0] ovr_a = 10'h000, ovr_b = 10'h000;
  logic ovr_valid = 1'b0, ecc_c = 1'b0, ecc_u = 1'b0;
  logic led_link, led_panel_link, led_crs, led_col, an_done, led_char_err, led_disp_err;
  logic powerdown, loop_out;
  logic [1:0] ecc_status;
  int mismatches = 0, checks_done = 0, len;
  always #5 ref_clk = ~ref_clk;
  ptls_top #(.AN_LINK_CYCLES(AN_CYC)) dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tbi_tx_clk(tbi_tx_clk), .tbi_tx_d(tbi_tx_d),
    .tbi_rx_clk(tbi_rx_clk), .tbi_rx_d(tbi_rx_d), .led_link(led_link),
    .led_panel_link(led_panel_link), .led_crs(led_crs), .led_col(led_col),
    .autoneg_done_indicator(an_done), .led_char_err(led_char_err), .led_disp_err(led_disp_err),
    .powerdown(powerdown), .serializer_loopback_out(loop_out), .ecc_corrected(ecc_c),
    .ecc_uncorrectable(ecc_u), .ecc_status(ecc_status));
  ptls_serdes_model #(.SHIFT(3)) serdes_u (.ovr_valid(ovr_valid), .ovr_a(ovr_a), .ovr_b(ovr_b),
    .took(took), .tbi_tx_clk(tbi_tx_clk), .tbi_rx_clk(tbi_rx_clk), .tbi_rx_d(tbi_rx_d));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (s !== v)
    begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    wait_lvl(pready, 1'b1, 8);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_see(input logic [7:0] a, input logic [31:0] d, ref logic s, input logic v);
    apb(1'b1, a, d);
    repeat (3) @(posedge ref_clk);
    check(32'(s), 32'(v));
  endtask
  task automatic send_pair(input logic [9:0] a, input logic [9:0] b);
    ovr_a <= a;
    ovr_b <= b;
    ovr_valid <= 1'b1;
    wait_lvl(took, 1'b1, 100);
    ovr_valid <= 1'b0;
  endtask
  task automatic pulse_len(ref logic s);
    wait_lvl(s, 1'b1, 400);
    len = 0;
    while (s === 1'b1 && len < 100)
    begin
      @(posedge ref_clk);
      len++;
    end
  endtask
  task automatic t_reset();
    check(32'({led_link, led_panel_link, led_crs, led_col, an_done, led_char_err,
      led_disp_err, powerdown, loop_out, ecc_status}), 32'h0000_0000);
    check(32'(tbi_tx_d), 32'(PTLS_K285_NEG));
    $display("t_reset done");
  endtask
  task automatic t_sync();
    wait_lvl(led_link, 1'b1, 2000);
    repeat (3) @(posedge ref_clk);
    check(32'(led_crs), 32'h0000_0000);
    check(32'(led_panel_link), 32'(led_link));
    apb(1'b0, PTLS_RXCODE_OFS, 32'h0000_0000);
    check(32'(q == PTLS_K285_NEG || q == PTLS_D162_NEG), 32'h0000_0001);
    $display("t_sync done");
  endtask
  task automatic t_an();
    wr_see(PTLS_CTRL_OFS, 32'h0000_0001, an_done, 1'b0);
    wait_lvl(an_done, 1'b1, AN_CYC + 20);
    repeat (2) @(posedge ref_clk);
    check(32'(led_panel_link), 32'h0000_0001);
    wr_see(PTLS_CTRL_OFS, 32'h0000_0005, led_panel_link, 1'b0);
    wr_see(PTLS_PARTAB_OFS, 32'h0000_8000, led_panel_link, 1'b1);
    wr_see(PTLS_CTRL_OFS, 32'h0000_000D, led_panel_link, 1'b0);
    wr_see(PTLS_DEVAB_OFS, 32'h0000_8000, led_panel_link, 1'b1);
    $display("t_an done");
  endtask
  task automatic t_tx_col();
    apb(1'b1, PTLS_CTRL_OFS, 32'h0000_0014);
    apb(1'b1, PTLS_TXCODE_OFS, 32'(DATA_GRP));
    repeat (30) @(posedge ref_clk);
    check(32'(tbi_tx_d), 32'(DATA_GRP));
    check(32'({led_crs, led_col}), 32'h0000_0002);
    ovr_a <= DATA_GRP;
    ovr_b <= DATA_GRP;
    ovr_valid <= 1'b1;
    wait_lvl(led_col, 1'b1, 200);
    wr_see(PTLS_CTRL_OFS, 32'h0000_0004, led_col, 1'b0);
    wr_see(PTLS_CTRL_OFS, 32'h0000_0010, led_col, 1'b0);
    ovr_valid <= 1'b0;
    apb(1'b1, PTLS_TXCODE_OFS, 32'(PTLS_D56));
    repeat (60) @(posedge ref_clk);
    check(32'(led_crs), 32'h0000_0000);
    $display("t_tx_col done");
  endtask
  task automatic t_ctrl();
    wr_see(PTLS_CTRL_OFS, 32'h0000_0020, powerdown, 1'b1);
    wr_see(PTLS_CTRL_OFS, 32'h0000_0040, loop_out, 1'b1);
    check(32'(powerdown), 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    check({q[30:0], e}, 32'h0000_0001);
    wr_see(PTLS_CTRL_OFS, 32'h0000_0000, loop_out, 1'b0);
    $display("t_ctrl done");
  endtask
  task automatic t_err();
    send_pair(PTLS_D56, 10'h3FF);
    pulse_len(led_char_err);
    check(32'(len), 32'd16);
    send_pair(PTLS_D56, PTLS_D162_NEG);
    pulse_len(led_disp_err);
    check(32'(len), 32'd16);
    $display("t_err done");
  endtask
  task automatic t_ecc();
    logic [1:0] exp [4];
    exp = '{PTLS_ECC_NONE, PTLS_ECC_CORR, PTLS_ECC_UNCORR, PTLS_ECC_UNCORR};
    for (int i = 0; i < 4; i++)
    begin
      ecc_c <= i[0];
      ecc_u <= i[1];
      repeat (2) @(posedge ref_clk);
      check(32'(ecc_status), 32'(exp[i]));
    end
    $display("t_ecc done");
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_sync();
    t_an();
    t_tx_col();
    t_ctrl();
    t_ecc();
    t_err();
    wrap_up();
  end
  initial
  begin
    #900000;
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
